//--- selftest_diag_pkg.sv
// package: constants for the self-test launch and safety check control block
// assumes: shared by the control block and its test engine sequencer
package selftest_diag_pkg;
  // launch register fields
  localparam int LAUNCH_RUN_BIT = 0;
  localparam int LAUNCH_ENPIN_DIAG_BIT = 1;
  localparam int LAUNCH_RSTDRV_DIAG_BIT = 2;
  localparam int LAUNCH_NVM_DIAG_BIT = 3;
  localparam int LAUNCH_CFG_DIAG_BIT = 4;
  localparam int LAUNCH_SELFTEST_DIAG_BIT = 5;
  localparam logic [7:0] LAUNCH_WRITABLE = 8'h3f;
  localparam logic [7:0] LAUNCH_RESET = 8'h00;
  // check control register fields
  localparam int CHECK_LEAVE_REQ_BIT = 0;
  localparam int CHECK_ESM_EN_BIT = 2;
  localparam int CHECK_ENABLE_PIN_DRIVER_ON_BIT = 3;
  localparam int CHECK_CFG_CRC_EN_BIT = 4;
  localparam logic [7:0] CHECK_WRITABLE = 8'h1d;
  localparam logic [7:0] CHECK_RESET = 8'h00;
  // error status fields (selftest_error_status)
  localparam int STAT_RUN_DONE_BIT = 0;
  localparam int STAT_RUN_ERR_BIT = 1;
  localparam int STAT_DIAG_ERR_BIT = 2;
  localparam int STAT_ENPIN_BIT = 3;
  localparam int STAT_RSTDRV_BIT = 4;
  localparam int STAT_NVM_BIT = 5;
  localparam int STAT_CFG_BIT = 6;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // test durations in cycles (arbitrary engine lengths)
  localparam int RUN_CYCLES = 64;
  localparam int CHECK_CYCLES = 16;
  localparam int CNT_W = 8;
  // device states
  typedef enum logic [2:0] {
    DEV_DIAGNOSTIC = 3'b001,
    DEV_ACTIVE = 3'b010,
    DEV_SAFE = 3'b100
  } dev_state_e;
endpackage : selftest_diag_pkg

//--- selftest_engine.sv
// test engine: runs one test at a time for a fixed number of cycles
// assumes: a start pulse only arrives while idle
`timescale 1ns/1ps
module selftest_engine
  import selftest_diag_pkg::*;
#(
  parameter int LEN = RUN_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] cnt_r;

  // countdown; done is a one-cycle pulse in the cycle after the last busy cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cnt_r <= CNT_W'(LEN - 1);
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_r == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end
endmodule : selftest_engine

//--- selftest_diag_control.sv
// self-test launch control, diagnostic checks and safety check control register
// assumes: host register commands arrive decoded as one-cycle write strobes on MCLK
// Function
// - bit 5 starts self-test diagnostic forcing an error, result in D0 and D2
// - bit 4 starts config checksum diagnostic, result D6, self-clears
// - bit 3 starts nvm checksum diagnostic, result D5, self-clears
// - bit 2 checks reset driver monitor mismatch detection, result D4, self-clears
// - bit 1 checks enable pin monitor mismatch detection, result D3, self-clears
// - bit 0 starts self-test run in diagnostic, active or safe, status D0 D1
// - run launched in diagnostic clears leave mask; diagnostic timeout keeps running
// - run in active or safe holds enable pin level until run completes
// - run start bit self-clears when run ends; bits 7..6 read zero
// - check control register resets on power-on and device reset
// - check control writes take effect only while lock is clear
// - check control fields at bits 4,3,2,0 reset zero; others read zero
// - leave request with mask clear moves diagnostic to active
`timescale 1ns/1ps
module selftest_diag_control
  import selftest_diag_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic DEVICE_RESET,
  input wire logic LAUNCH_WR,
  input wire logic [7:0] LAUNCH_WDATA,
  input wire logic CHECK_WR,
  input wire logic [7:0] CHECK_WDATA,
  input wire logic LOCK,
  input wire logic MASK_SET,
  input wire logic ENTER_SAFE,
  input wire logic SELFTEST_FAIL,
  input wire logic ENABLE_PIN_LEVEL,
  output logic [7:0] LAUNCH_RDATA,
  output logic [7:0] CHECK_RDATA,
  output logic [7:0] STATUS_RDATA,
  output logic DIAG_LEAVE_MASK,
  output logic [2:0] DEV_STATE,
  output logic ENABLE_PIN_HELD,
  output logic ENABLE_PIN_HOLD_LEVEL
);
  logic [7:0] launch_r;
  logic [7:0] check_r;
  logic [7:0] status_r;
  logic mask_r;
  dev_state_e state_r;
  logic hold_r;
  logic hold_lvl_r;
  logic run_busy, run_done, chk_busy, chk_done;
  logic [2:0] cur_r; // which short check is running: bit index 1..5
  logic run_go, chk_go;
  logic [7:0] launch_set;
  logic leave_now;
  logic pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r;
  // done is registered after the last busy cycle, so it is sampled one cycle past the run length
  localparam int RUN_DONE_LAT = RUN_CYCLES + 1;

  // enable pin level comes from the pad: three stages, a change counts once stages two and three agree
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      pin_lvl_r <= 1'b0;
    end else begin
      pin_s1_r <= ENABLE_PIN_LEVEL;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) pin_lvl_r <= pin_s3_r; // glitch shorter than two cycles is dropped
    end
  end

  // new starts only on bits written 1 and not already pending
  assign launch_set = (LAUNCH_WR && !LOCK) ? (LAUNCH_WDATA & LAUNCH_WRITABLE) : 8'h00;
  assign run_go = launch_r[LAUNCH_RUN_BIT] && !run_busy && !run_done;
  assign chk_go = (launch_r[5:1] != 5'h00) && !chk_busy && !chk_done;
  assign leave_now = (state_r == DEV_DIAGNOSTIC) && check_r[CHECK_LEAVE_REQ_BIT] && !mask_r;

  selftest_engine #(.LEN(RUN_CYCLES)) u_run (
    .clk(MCLK), .rst_n(RST_N), .start(run_go), .busy(run_busy), .done(run_done)
  );
  selftest_engine #(.LEN(CHECK_CYCLES)) u_chk (
    .clk(MCLK), .rst_n(RST_N), .start(chk_go), .busy(chk_busy), .done(chk_done)
  );

  // pick lowest pending check at launch; one check at a time keeps status unambiguous
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_r <= 3'h0;
    end else if (chk_go) begin
      if (launch_r[1]) cur_r <= 3'h1;
      else if (launch_r[2]) cur_r <= 3'h2;
      else if (launch_r[3]) cur_r <= 3'h3;
      else if (launch_r[4]) cur_r <= 3'h4;
      else cur_r <= 3'h5;
    end
  end

  // launch register: zeros written are ignored, bits clear when their test ends
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      launch_r <= LAUNCH_RESET;
    end else if (DEVICE_RESET) begin
      launch_r <= LAUNCH_RESET;
    end else begin
      logic [7:0] nxt;
      nxt = launch_r;
      if (run_done) nxt[LAUNCH_RUN_BIT] = 1'b0;
      if (chk_done) nxt[cur_r] = 1'b0;
      launch_r <= (nxt | launch_set) & LAUNCH_WRITABLE;
    end
  end

  // status: run result in D0/D1, diag run result in D0/D2, checks in D3..D6
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      status_r <= STAT_RESET;
    end else if (DEVICE_RESET) begin
      status_r <= STAT_RESET;
    end else begin
      if (run_done) begin
        status_r[STAT_RUN_DONE_BIT] <= 1'b1;
        status_r[STAT_RUN_ERR_BIT] <= SELFTEST_FAIL;
      end
      if (chk_done) begin
        unique case (cur_r)
          3'h1: status_r[STAT_ENPIN_BIT] <= 1'b1;
          3'h2: status_r[STAT_RSTDRV_BIT] <= 1'b1;
          3'h3: status_r[STAT_NVM_BIT] <= 1'b1;
          3'h4: status_r[STAT_CFG_BIT] <= 1'b1;
          default: begin
            // forced-error self-test: a working checker must flag the error
            status_r[STAT_RUN_DONE_BIT] <= 1'b1;
            status_r[STAT_DIAG_ERR_BIT] <= 1'b1;
          end
        endcase
      end
    end
  end

  // check control register, lock gated; leave request cleared outside diagnostic
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      check_r <= CHECK_RESET;
    end else if (DEVICE_RESET) begin
      check_r <= CHECK_RESET;
    end else begin
      logic [7:0] nxt;
      nxt = check_r;
      if (CHECK_WR && !LOCK) nxt = CHECK_WDATA & CHECK_WRITABLE;
      if (state_r != DEV_DIAGNOSTIC || leave_now) nxt[CHECK_LEAVE_REQ_BIT] = 1'b0;
      if (ENTER_SAFE) nxt[CHECK_ENABLE_PIN_DRIVER_ON_BIT] = 1'b0;
      check_r <= nxt;
    end
  end

  // leave mask: cleared when a run starts in diagnostic, host may set it again
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_r <= 1'b0;
    end else if (DEVICE_RESET) begin
      mask_r <= 1'b0;
    end else if (run_go && state_r == DEV_DIAGNOSTIC) begin
      mask_r <= 1'b0;
    end else if (MASK_SET) begin
      mask_r <= 1'b1;
    end
  end

  // device state; diagnostic timeout lives elsewhere and is not paused by a run
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= DEV_DIAGNOSTIC;
    end else if (DEVICE_RESET) begin
      state_r <= DEV_DIAGNOSTIC;
    end else if (ENTER_SAFE) begin
      state_r <= DEV_SAFE;
    end else if (leave_now) begin
      state_r <= DEV_ACTIVE;
    end
  end

  // enable pin hold across a run in active or safe
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_r <= 1'b0;
      hold_lvl_r <= 1'b0;
    end else if (run_go && state_r != DEV_DIAGNOSTIC) begin
      hold_r <= 1'b1;
      hold_lvl_r <= pin_lvl_r;
    end else if (run_done) begin
      hold_r <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      LAUNCH_RDATA <= 8'h00;
      CHECK_RDATA <= 8'h00;
      STATUS_RDATA <= 8'h00;
      DIAG_LEAVE_MASK <= 1'b0;
      DEV_STATE <= 3'h1;
      ENABLE_PIN_HELD <= 1'b0;
      ENABLE_PIN_HOLD_LEVEL <= 1'b0;
    end else begin
      LAUNCH_RDATA <= launch_r & LAUNCH_WRITABLE;
      CHECK_RDATA <= check_r & CHECK_WRITABLE;
      STATUS_RDATA <= status_r;
      DIAG_LEAVE_MASK <= mask_r;
      DEV_STATE <= state_r;
      ENABLE_PIN_HELD <= hold_r;
      ENABLE_PIN_HOLD_LEVEL <= hold_lvl_r;
    end
  end

  locked_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CHECK_WR && LOCK && !DEVICE_RESET && !ENTER_SAFE && state_r == DEV_DIAGNOSTIC && !leave_now)
      |=> check_r == $past(check_r)) else $error("locked write changed check register");
  run_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (run_done && !DEVICE_RESET && !launch_set[0]) |=> !launch_r[LAUNCH_RUN_BIT])
    else $error("run bit not cleared");
  run_length_a: assert property (@(posedge MCLK) disable iff (!RST_N || DEVICE_RESET)
    run_go |-> ##[RUN_DONE_LAT:RUN_DONE_LAT] run_done) else $error("run length wrong");
  mask_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (run_go && state_r == DEV_DIAGNOSTIC && !DEVICE_RESET) |=> !mask_r) else $error("mask not cleared");
  leave_diag_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (leave_now && !ENTER_SAFE && !DEVICE_RESET) |=> state_r == DEV_ACTIVE) else $error("no leave to active");
  hold_run_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    hold_r |-> run_busy || run_done) else $error("pin held without run");
  cfg_status_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (chk_done && cur_r == 3'h4 && !DEVICE_RESET) |=> status_r[STAT_CFG_BIT]) else $error("cfg status missing");
  zero_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (run_busy && !run_done && !DEVICE_RESET) |=> launch_r[LAUNCH_RUN_BIT]) else $error("run aborted");
endmodule : selftest_diag_control

//--- host_model.sv
// host model: issues register writes and mask requests to the self-test control block
// assumes: strobes are sampled on the rising clock edge and last one cycle
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic launch_wr,
  output logic [7:0] launch_wdata,
  output logic check_wr,
  output logic [7:0] check_wdata,
  output logic mask_set
);
  // idle bus; released data is inverted so stale data never looks valid
  initial begin
    launch_wr = 1'b0;
    launch_wdata = 8'h00;
    check_wr = 1'b0;
    check_wdata = 8'h00;
    mask_set = 1'b0;
  end
  // one launch register write, strobe held over one rising edge
  task automatic wr_launch(input logic [7:0] d);
    @(negedge clk);
    launch_wr = 1'b1;
    launch_wdata = d;
    @(negedge clk);
    launch_wr = 1'b0;
    launch_wdata = ~d;
  endtask : wr_launch
  // check control write; only meaningful while the lock is clear
  task automatic wr_check(input logic [7:0] d);
    @(negedge clk);
    check_wr = 1'b1;
    check_wdata = d;
    @(negedge clk);
    check_wr = 1'b0;
    check_wdata = ~d;
  endtask : wr_check
  // host re-arms the leave mask to stay in diagnostic
  task automatic set_mask();
    @(negedge clk);
    mask_set = 1'b1;
    @(negedge clk);
    mask_set = 1'b0;
  endtask : set_mask
endmodule : host_model

//--- test_selftest_diag_control.sv
// testbench: drives the self-test control block through the host model
// assumes: 200 MHz clock, inputs changed at the falling edge
`timescale 1ns/1ps
module test_selftest_diag_control;
  import selftest_diag_pkg::*;
  logic mclk, rst_n, dev_rst, lock;
  logic safe_req, st_fail, pin_lvl;
  logic launch_wr, check_wr, mask_set, leave_mask, pin_held, pin_hold_lvl;
  logic [7:0] launch_wdata, check_wdata, launch_rd, check_rd, stat_rd;
  logic [2:0] dev_state;
  int mismatches = 0;
  int samples_checked = 0;
  always #2.5 mclk = ~mclk;
  host_model u_host (.clk(mclk), .launch_wr(launch_wr), .launch_wdata(launch_wdata),
    .check_wr(check_wr), .check_wdata(check_wdata), .mask_set(mask_set));
  selftest_diag_control u_dut (.MCLK(mclk), .RST_N(rst_n), .DEVICE_RESET(dev_rst),
    .LAUNCH_WR(launch_wr), .LAUNCH_WDATA(launch_wdata), .CHECK_WR(check_wr),
    .CHECK_WDATA(check_wdata), .LOCK(lock), .MASK_SET(mask_set), .ENTER_SAFE(safe_req),
    .SELFTEST_FAIL(st_fail), .ENABLE_PIN_LEVEL(pin_lvl), .LAUNCH_RDATA(launch_rd),
    .CHECK_RDATA(check_rd), .STATUS_RDATA(stat_rd), .DIAG_LEAVE_MASK(leave_mask),
    .DEV_STATE(dev_state), .ENABLE_PIN_HELD(pin_held), .ENABLE_PIN_HOLD_LEVEL(pin_hold_lvl));
  // single compare for all 8-bit results
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // bounded wait for a start bit to self-clear
  task automatic wait_clear(input int b);
    int n;
    n = 0;
    while (launch_rd[b] !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    cmp({7'h00, launch_rd[b]}, 8'h00);
  endtask : wait_clear
  task automatic chk_reset_vals();
    cmp(launch_rd, LAUNCH_RESET);
    cmp(check_rd, CHECK_RESET);
    cmp(stat_rd, STAT_RESET);
    cmp({5'h00, dev_state}, 8'h01);
  endtask : chk_reset_vals
  // reserved bits stay zero, lock refuses writes
  task automatic t_check_reg();
    u_host.wr_check(8'hfe);
    repeat (2) @(negedge mclk);
    cmp(check_rd, 8'h1c);
    lock = 1'b1;
    u_host.wr_check(8'h00);
    repeat (2) @(negedge mclk);
    cmp(check_rd, 8'h1c);
    lock = 1'b0;
    $display("test check_reg done");
  endtask : t_check_reg
  // run in diagnostic: mask cleared, zero write does not abort, then leave
  task automatic t_run_diag();
    st_fail = 1'b1;
    u_host.set_mask();
    repeat (2) @(negedge mclk);
    cmp({7'h00, leave_mask}, 8'h01);
    u_host.wr_launch(8'h01);
    repeat (3) @(negedge mclk);
    cmp(launch_rd, 8'h01);
    cmp({7'h00, leave_mask}, 8'h00);
    u_host.wr_launch(8'h00);
    repeat (2) @(negedge mclk);
    cmp(launch_rd, 8'h01);
    wait_clear(0);
    @(negedge mclk);
    cmp(stat_rd & 8'h03, 8'h03);
    cmp({5'h00, dev_state}, 8'h01);
    u_host.wr_check(8'h1d);
    repeat (4) @(negedge mclk);
    cmp({5'h00, dev_state}, 8'h02);
    cmp(check_rd, 8'h1c);
    $display("test run_diag done");
  endtask : t_run_diag
  // run in active: pin level latched at start, released at the end
  task automatic t_run_active();
    pin_lvl = 1'b1;
    st_fail = 1'b0;
    // let the pin level pass the synchroniser before the run latches it
    repeat (6) @(negedge mclk);
    u_host.wr_launch(8'h01);
    repeat (3) @(negedge mclk);
    pin_lvl = 1'b0;
    repeat (2) @(negedge mclk);
    cmp({6'h00, pin_held, pin_hold_lvl}, 8'h03);
    wait_clear(0);
    repeat (2) @(negedge mclk);
    cmp({7'h00, pin_held}, 8'h00);
    cmp(stat_rd & 8'h03, 8'h01);
    $display("test run_active done");
  endtask : t_run_active
  // reserved launch bits, then each diagnostic start bit in turn
  task automatic t_diags();
    u_host.wr_launch(8'hc0);
    repeat (2) @(negedge mclk);
    cmp(launch_rd, 8'h00);
    for (int b = 1; b < 6; b++) begin
      u_host.wr_launch(8'h01 << b);
      repeat (2) @(negedge mclk);
      cmp(launch_rd, 8'h01 << b);
      wait_clear(b);
    end
    @(negedge mclk);
    cmp(stat_rd & 8'h05, 8'h05);
    cmp(stat_rd, 8'h7d);
    $display("test diags done");
  endtask : t_diags
  // safe state clears pin driver enable, run still allowed, device reset restores launch, check, status and state
  task automatic t_safe_reset();
    safe_req = 1'b1;
    @(negedge mclk);
    safe_req = 1'b0;
    repeat (2) @(negedge mclk);
    cmp({5'h00, dev_state}, 8'h04);
    cmp(check_rd, 8'h14);
    u_host.wr_launch(8'h01);
    repeat (2) @(negedge mclk);
    cmp(launch_rd, 8'h01);
    cmp({6'h00, pin_held, pin_hold_lvl}, 8'h02);
    wait_clear(0);
    dev_rst = 1'b1;
    @(negedge mclk);
    dev_rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk_reset_vals();
    $display("test safe_reset done");
  endtask : t_safe_reset
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // tests need well under a thousand cycles; a hang is cut at five thousand
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    dev_rst = 1'b0;
    lock = 1'b0;
    safe_req = 1'b0;
    st_fail = 1'b0;
    pin_lvl = 1'b0;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk_reset_vals();
    t_check_reg();
    t_run_diag();
    t_run_active();
    t_diags();
    t_safe_reset();
    wrap_up();
  end
endmodule : test_selftest_diag_control
